// ===== verilog/digipot_pkg.sv
// Purpose: Shared constants, types and saturating helpers for the digipot command decoder
// Assumes: Dual-channel build, 16-bit serial word, 8-bit wiper, 16 stored locations
// Notes: All timing is counted in cycles of the 100 MHz system clock
package digipot_pkg;

    localparam int WORD_W = 16;
    localparam int CMD_W = 4;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CMD_MSB = 15;
    localparam int ADDR_MSB = 11;
    localparam int DATA_MSB = 7;
    localparam int NUM_WIPERS = 2;
    localparam int WIDX_W = 1;
    localparam int NV_DEPTH = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;
    localparam logic [DATA_W-1:0] NV_RESET = 8'h80;
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
    localparam logic [DATA_W-1:0] ALL_ZEROS = 8'h00;
    localparam logic [ADDR_W-1:0] RELOAD_ADDR = 4'h0;

    // Nonvolatile save time and its cycle count, rounded up
    localparam int SAVE_TIME_NS = 20200000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SAVE_CYCLES = (SAVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 22;

    typedef enum logic [CMD_W-1:0] {
        CMD_IDLE = 4'h0,
        CMD_NV_TO_WIPER = 4'h1,
        CMD_SAVE_WIPER = 4'h2,
        CMD_NV_WRITE = 4'h3,
        CMD_SHR_ONE = 4'h4,
        CMD_SHR_ALL = 4'h5,
        CMD_DEC_ONE = 4'h6,
        CMD_DEC_ALL = 4'h7,
        CMD_RELOAD_ALL = 4'h8,
        CMD_READ_NV = 4'h9,
        CMD_READ_WIPER = 4'ha,
        CMD_WIPER_WRITE = 4'hb,
        CMD_SHL_ONE = 4'hc,
        CMD_SHL_ALL = 4'hd,
        CMD_INC_ONE = 4'he,
        CMD_INC_ALL = 4'hf
    } cmd_t;

    typedef enum logic [1:0] {
        ST_SWEEP = 2'b00,
        ST_IDLE = 2'b01
    } state_t;

    function automatic logic [DATA_W-1:0] sat_inc(input logic [DATA_W-1:0] v);
        sat_inc = (v == ALL_ONES) ? v : v + 8'h01;
    endfunction : sat_inc

    function automatic logic [DATA_W-1:0] sat_dec(input logic [DATA_W-1:0] v);
        sat_dec = (v == ALL_ZEROS) ? v : v - 8'h01;
    endfunction : sat_dec

    // Ones fill from the bottom so the shift climbs to all ones
    function automatic logic [DATA_W-1:0] sat_shl(input logic [DATA_W-1:0] v);
        sat_shl = {v[DATA_W-2:0], 1'b1};
    endfunction : sat_shl

    function automatic logic [DATA_W-1:0] sat_shr(input logic [DATA_W-1:0] v);
        sat_shr = {1'b0, v[DATA_W-1:1]};
    endfunction : sat_shr

endpackage : digipot_pkg

// ===== verilog/digipot_ifs.sv
// Purpose: Carriers between the decoder, the serial shifter and the stored-value array
// Assumes: All signals on the system clock
// Notes: Handshakes are single-cycle pulses
interface ser_if;
    logic [digipot_pkg::WORD_W-1:0] word;
    logic word_valid;
    logic load;
    logic [digipot_pkg::DATA_W-1:0] load_data;
    logic lock;
    modport shifter (output word, output word_valid, input load, input load_data, input lock);
    modport decoder (input word, input word_valid, output load, output load_data, output lock);
endinterface : ser_if

interface nv_if;
    logic [digipot_pkg::ADDR_W-1:0] rd_addr;
    logic [digipot_pkg::DATA_W-1:0] rd_data;
    logic wr_en;
    logic [digipot_pkg::ADDR_W-1:0] wr_addr;
    logic [digipot_pkg::DATA_W-1:0] wr_data;
    logic busy;
    modport store (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data,
        output busy);
    modport decoder (output rd_addr, input rd_data, output wr_en, output wr_addr,
        output wr_data, input busy);
endinterface : nv_if

// ===== verilog/serial_word_shifter.sv
// Purpose: Serial input shift register with readback load and open-drain serial out
// Assumes: Clock-low idle serial mode, pins asynchronous to CLK, SCLK well below CLK/4
// Notes: A word is handed on only if exactly sixteen bits arrived while selected
module serial_word_shifter
    import digipot_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk_pin,
    input wire logic cs_n_pin,
    input wire logic sdi_pin,
    ser_if.shifter ser,
    output logic sdo_oe
);
    logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
    logic sdi_s1_ff, sdi_s2_ff;
    logic [WORD_W-1:0] shift_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic sdo_oe_ff;
    logic sclk_rise, cs_rise, cs_fall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_s3_ff <= 1'b0;
            cs_s1_ff <= 1'b1;
            cs_s2_ff <= 1'b1;
            cs_s3_ff <= 1'b1;
            sdi_s1_ff <= 1'b0;
            sdi_s2_ff <= 1'b0;
        end else begin
            sclk_s1_ff <= sclk_pin;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            cs_s1_ff <= cs_n_pin;
            cs_s2_ff <= cs_s1_ff;
            cs_s3_ff <= cs_s2_ff;
            sdi_s1_ff <= sdi_pin;
            sdi_s2_ff <= sdi_s1_ff;
        end
    end

    assign sclk_rise = sclk_s2_ff && !sclk_s3_ff;
    assign cs_rise = cs_s2_ff && !cs_s3_ff;
    assign cs_fall = !cs_s2_ff && cs_s3_ff;

    // Shifting is frozen while a save runs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_ff <= '0;
        end else if (ser.load) begin
            shift_ff[DATA_MSB:0] <= ser.load_data;
        end else if (sclk_rise && !cs_s2_ff && !ser.lock) begin
            shift_ff <= {shift_ff[WORD_W-2:0], sdi_s2_ff};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (cs_fall) begin
            cnt_ff <= '0;
        end else if (sclk_rise && !cs_s2_ff && !ser.lock && cnt_ff != 5'h1f) begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end

    // Previous word leaves at the top as the new one enters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_oe_ff <= 1'b0;
        end else begin
            sdo_oe_ff <= !cs_s2_ff && !shift_ff[WORD_W-1];
        end
    end

    assign sdo_oe = sdo_oe_ff;
    assign ser.word = shift_ff;
    assign ser.word_valid = cs_rise && (cnt_ff == FULL_COUNT);
endmodule : serial_word_shifter

// ===== verilog/nv_store.sv
// Purpose: Stored wiper and user values with a timed save window
// Assumes: One write at a time; writes while busy are dropped by the caller
// Notes: SYS_RST stands in for first power-up and fills every location with midscale
module nv_store
    import digipot_pkg::*;
#(
    parameter int SAVE_CYC = SAVE_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    nv_if.store nv
);
    logic [DATA_W-1:0] mem_ff [NV_DEPTH];
    logic [TIMER_W-1:0] timer_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NV_DEPTH; i++) begin
                mem_ff[i] <= NV_RESET;
            end
        end else if (nv.wr_en && timer_ff == '0) begin
            mem_ff[nv.wr_addr] <= nv.wr_data;
        end
    end

    // Models the programming time; the array is updated at its start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_ff <= '0;
        end else if (nv.wr_en && timer_ff == '0) begin
            timer_ff <= TIMER_W'(SAVE_CYC);
        end else if (timer_ff != '0) begin
            timer_ff <= timer_ff - 22'h000001;
        end
    end

    assign nv.busy = (timer_ff != '0);
    assign nv.rd_data = mem_ff[nv.rd_addr];
endmodule : nv_store

// ===== verilog/digipot_command_decoder.sv
// Purpose: Executes the sixteen serial commands of a dual nonvolatile digital potentiometer
// Assumes: Serial pins asynchronous to CLK; host waits for ready after saves and reloads
// Notes: Open-drain pins are driven low only while their enable is high
module digipot_command_decoder
    import digipot_pkg::*;
#(
    parameter int SAVE_CYC = SAVE_CYCLES
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SDI,
    input wire logic WP_N,
    output logic SDO_O,
    output logic SDO_OE,
    output logic RDY_O,
    output logic RDY_OE,
    output logic [digipot_pkg::NUM_WIPERS*digipot_pkg::DATA_W-1:0] WIPER_POS
);
    import digipot_pkg::*;

    ser_if ser();
    nv_if nv();

    logic wp_s1_ff, wp_s2_ff;
    state_t state_ff, nxt_state;
    logic [WIDX_W-1:0] sweep_ff, nxt_sweep;
    logic [DATA_W-1:0] wiper_ff [NUM_WIPERS];
    logic [DATA_W-1:0] nxt_wiper [NUM_WIPERS];
    logic rdy_oe_ff;
    cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [WIDX_W-1:0] widx;
    logic sel_ok, wr_ok, exec;

    serial_word_shifter u_shifter (
        .clk(CLK),
        .rst(SYS_RST),
        .sclk_pin(SCLK),
        .cs_n_pin(CS_N),
        .sdi_pin(SDI),
        .ser(ser.shifter),
        .sdo_oe(SDO_OE)
    );

    nv_store #(.SAVE_CYC(SAVE_CYC)) u_store (
        .clk(CLK),
        .rst(SYS_RST),
        .nv(nv.store)
    );

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            wp_s1_ff <= 1'b1;
            wp_s2_ff <= 1'b1;
        end else begin
            wp_s1_ff <= WP_N;
            wp_s2_ff <= wp_s1_ff;
        end
    end

    assign cmd = cmd_t'(ser.word[CMD_MSB -: CMD_W]);
    assign addr = ser.word[ADDR_MSB -: ADDR_W];
    assign data = ser.word[DATA_MSB:0];
    assign widx = addr[WIDX_W-1:0];
    assign sel_ok = (addr < ADDR_W'(NUM_WIPERS));
    assign wr_ok = wp_s2_ff;
    assign exec = ser.word_valid && (state_ff == ST_IDLE) && !nv.busy;
    assign ser.lock = nv.busy;
    assign nv.rd_addr = (state_ff == ST_SWEEP) ? ADDR_W'(sweep_ff) : addr;
    assign nv.wr_addr = addr;

    always_comb begin
        nxt_state = state_ff;
        nxt_sweep = sweep_ff;
        for (int i = 0; i < NUM_WIPERS; i++) begin
            nxt_wiper[i] = wiper_ff[i];
        end
        nv.wr_en = 1'b0;
        nv.wr_data = '0;
        ser.load = 1'b0;
        ser.load_data = '0;
        case (state_ff)
            ST_SWEEP: begin
                nxt_wiper[sweep_ff] = nv.rd_data;
                if (sweep_ff == WIDX_W'(NUM_WIPERS - 1)) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_sweep = sweep_ff + 1'b1;
                end
            end
            ST_IDLE: begin
                if (exec) begin
                    case (cmd)
                        CMD_IDLE: begin
                            nxt_state = ST_IDLE;
                        end
                        CMD_NV_TO_WIPER: begin
                            if (sel_ok) begin
                                nxt_wiper[widx] = nv.rd_data;
                            end
                        end
                        CMD_SAVE_WIPER: begin
                            if (sel_ok && wr_ok) begin
                                nv.wr_en = 1'b1;
                                nv.wr_data = wiper_ff[widx];
                            end
                        end
                        CMD_NV_WRITE: begin
                            if (wr_ok) begin
                                nv.wr_en = 1'b1;
                                nv.wr_data = data;
                            end
                        end
                        CMD_SHR_ONE: begin
                            if (sel_ok && wr_ok) begin
                                nxt_wiper[widx] = sat_shr(wiper_ff[widx]);
                            end
                        end
                        CMD_DEC_ONE: begin
                            if (sel_ok && wr_ok) begin
                                nxt_wiper[widx] = sat_dec(wiper_ff[widx]);
                            end
                        end
                        CMD_SHL_ONE: begin
                            if (sel_ok && wr_ok) begin
                                nxt_wiper[widx] = sat_shl(wiper_ff[widx]);
                            end
                        end
                        CMD_INC_ONE: begin
                            if (sel_ok && wr_ok) begin
                                nxt_wiper[widx] = sat_inc(wiper_ff[widx]);
                            end
                        end
                        CMD_SHR_ALL, CMD_DEC_ALL, CMD_SHL_ALL, CMD_INC_ALL: begin
                            for (int i = 0; i < NUM_WIPERS; i++) begin
                                if (wr_ok) begin
                                    case (cmd)
                                        CMD_SHR_ALL: nxt_wiper[i] = sat_shr(wiper_ff[i]);
                                        CMD_DEC_ALL: nxt_wiper[i] = sat_dec(wiper_ff[i]);
                                        CMD_SHL_ALL: nxt_wiper[i] = sat_shl(wiper_ff[i]);
                                        default: nxt_wiper[i] = sat_inc(wiper_ff[i]);
                                    endcase
                                end
                            end
                        end
                        CMD_RELOAD_ALL: begin
                            if (addr == RELOAD_ADDR && wr_ok) begin
                                nxt_state = ST_SWEEP;
                                nxt_sweep = '0;
                            end
                        end
                        CMD_READ_NV: begin
                            ser.load = 1'b1;
                            ser.load_data = nv.rd_data;
                        end
                        CMD_READ_WIPER: begin
                            ser.load = 1'b1;
                            ser.load_data = sel_ok ? wiper_ff[widx] : ALL_ZEROS;
                        end
                        CMD_WIPER_WRITE: begin
                            if (sel_ok && wr_ok) begin
                                nxt_wiper[widx] = data;
                            end
                        end
                        default: begin
                            nxt_state = ST_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Reset starts in the sweep so wipers come up from the store
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_ff <= ST_SWEEP;
            sweep_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            sweep_ff <= nxt_sweep;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < NUM_WIPERS; i++) begin
                wiper_ff[i] <= ALL_ZEROS;
            end
        end else begin
            for (int i = 0; i < NUM_WIPERS; i++) begin
                wiper_ff[i] <= nxt_wiper[i];
            end
        end
    end

    // Ready is pulled low through saves and reload sweeps
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rdy_oe_ff <= 1'b1;
        end else begin
            rdy_oe_ff <= nv.busy || nv.wr_en || (nxt_state == ST_SWEEP);
        end
    end

    assign RDY_OE = rdy_oe_ff;
    assign RDY_O = 1'b0;
    assign SDO_O = 1'b0;

    generate
        for (genvar g = 0; g < NUM_WIPERS; g++) begin : g_pos
            assign WIPER_POS[g*DATA_W +: DATA_W] = wiper_ff[g];
        end
    endgenerate

    property p_idle_word;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_IDLE |=> $stable(wiper_ff[0]) && $stable(wiper_ff[1]) && !nv.busy;
    endproperty
    a_idle_word: assert property (p_idle_word) else $error("idle command changed state");

    property p_inc;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_INC_ONE && sel_ok && wr_ok
            |=> wiper_ff[$past(widx)] == sat_inc($past(wiper_ff[widx]));
    endproperty
    a_inc: assert property (p_inc) else $error("increment result wrong");

    property p_dec_floor;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_DEC_ALL && wr_ok && wiper_ff[0] == ALL_ZEROS
            |=> wiper_ff[0] == ALL_ZEROS;
    endproperty
    a_dec_floor: assert property (p_dec_floor) else $error("decrement wrapped");

    property p_shl_top;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_SHL_ALL && wr_ok && wiper_ff[1] == ALL_ONES
            |=> wiper_ff[1] == ALL_ONES;
    endproperty
    a_shl_top: assert property (p_shl_top) else $error("left shift passed all ones");

    property p_write;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_WIPER_WRITE && sel_ok && wr_ok
            |=> wiper_ff[$past(widx)] == $past(data);
    endproperty
    a_write: assert property (p_write) else $error("direct wiper write lost");

    property p_protect;
        @(posedge CLK) disable iff (SYS_RST)
        exec && !wr_ok && cmd != CMD_NV_TO_WIPER
            |=> $stable(wiper_ff[0]) && $stable(wiper_ff[1]) && state_ff == ST_IDLE;
    endproperty
    a_protect: assert property (p_protect) else $error("protected wiper changed");

    property p_save_busy;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_SAVE_WIPER && sel_ok && wr_ok
            |=> (nv.busy && ser.lock && RDY_OE) [*8];
    endproperty
    a_save_busy: assert property (p_save_busy) else $error("save did not hold off");

    property p_readback;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_READ_WIPER && sel_ok
            |=> ser.word[DATA_MSB:0] == $past(wiper_ff[widx]);
    endproperty
    a_readback: assert property (p_readback) else $error("wiper readback wrong");

    property p_reload;
        @(posedge CLK) disable iff (SYS_RST)
        exec && cmd == CMD_RELOAD_ALL && addr == RELOAD_ADDR && wr_ok
            |=> RDY_OE ##[1:2] state_ff == ST_IDLE ##1 !RDY_OE;
    endproperty
    a_reload: assert property (p_reload) else $error("reload sweep timing wrong");

    property p_quiet;
        @(posedge CLK) disable iff (SYS_RST)
        !exec && state_ff == ST_IDLE |=> $stable(wiper_ff[0]) && $stable(wiper_ff[1]);
    endproperty
    a_quiet: assert property (p_quiet) else $error("wiper moved between commands");

endmodule : digipot_command_decoder

// ===== verif/spi_host_model.sv
// Purpose: Serial host that shifts words into the decoder and captures serial out
// Assumes: Clock idles low, serial out has a pull-up
// Notes: Each serial clock phase lasts five system cycles
module spi_host_model (
    input wire logic clk,
    input wire logic sdo_wire,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    task automatic phase();
        repeat (5) @(posedge clk);
        #1;
    endtask : phase

    // Sends the top n bits of w; a short count is used to provoke a refusal
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk);
        #1;
        cs_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            sdi = w[i];
            phase();
            rx = {rx[14:0], sdo_wire};
            sclk = 1'b1;
            phase();
            sclk = 1'b0;
        end
        phase();
        cs_n = 1'b1;
        // Released line must not keep showing the last bit
        sdi = ~sdi;
        repeat (5) @(posedge clk);
    endtask : xfer
endmodule : spi_host_model

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the digipot command decoder
// Assumes: Save time shortened to 400 cycles
// Notes: Table rows first, then saves, readback, protect, short word, reset
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import digipot_pkg::*;

    typedef struct packed {
        logic [15:0] word;
        logic [15:0] pos;
    } row_t;

    logic clk;
    logic sys_rst;
    logic wp_n;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo_o;
    logic sdo_oe;
    logic rdy_o;
    logic rdy_oe;
    logic sdo_wire;
    logic [15:0] wiper_pos;
    logic [15:0] rx;
    int err_count = 0;
    int comparisons = 0;
    row_t rows [20] = '{
        '{16'hb000, 16'h8000}, '{16'h7000, 16'h7f00}, '{16'h6055, 16'h7f00},
        '{16'h40aa, 16'h7f00},
        '{16'hb1ff, 16'hff00}, '{16'he1aa, 16'hff00}, '{16'hc155, 16'hff00},
        '{16'hf000, 16'hff01}, '{16'hd000, 16'hff03}, '{16'h7000, 16'hfe02},
        '{16'h5000, 16'h7f01}, '{16'he000, 16'h7f02}, '{16'hc000, 16'h7f05},
        '{16'h0e5a, 16'h7f05}, '{16'hb233, 16'h7f05}, '{16'h1000, 16'h7f80},
        '{16'h8100, 16'h7f80}, '{16'h6100, 16'h7e80}, '{16'h4100, 16'h3f80},
        '{16'h8000, 16'h8080}
    };

    assign sdo_wire = sdo_oe ? sdo_o : 1'b1;

    digipot_command_decoder #(.SAVE_CYC(400)) DUT (
        .CLK(clk), .SYS_RST(sys_rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .WP_N(wp_n),
        .SDO_O(sdo_o), .SDO_OE(sdo_oe), .RDY_O(rdy_o), .RDY_OE(rdy_oe), .WIPER_POS(wiper_pos)
    );

    spi_host_model host (.clk(clk), .sdo_wire(sdo_wire), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Bounded wait so a stuck busy flag shows as a mismatch
    task automatic wait_ready();
        int n = 0;
        while (rdy_oe !== 1'b0 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({15'h0000, rdy_oe}, 16'h0000);
        check({15'h0000, rdy_o}, 16'h0000);
    endtask : wait_ready

    task automatic send(input logic [15:0] w);
        host.xfer(w, 16, rx);
        repeat (4) @(posedge clk);
        #1;
        wait_ready();
    endtask : send

    initial begin
        #400us;
        err_count++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        wp_n = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        wait_ready();
        check(wiper_pos, 16'h8080);
        for (int i = 0; i < 20; i++) begin
            send(rows[i].word);
            check(wiper_pos, rows[i].pos);
            if (i > 0) begin
                check(rx, rows[i - 1].word);
            end
        end
        $display("table done");
        send(16'hb042);
        host.xfer(16'h2000, 16, rx);
        #1;
        check({15'h0000, rdy_oe}, 16'h0001);
        host.xfer(16'hb011, 16, rx);
        check(wiper_pos, 16'h8042);
        wait_ready();
        send(16'hb011);
        send(16'h1000);
        check(wiper_pos, 16'h8042);
        send(16'h31c3);
        send(16'h8000);
        check(wiper_pos, 16'hc342);
        $display("save done");
        send(16'ha100);
        send(16'h0000);
        check(rx, 16'ha1c3);
        send(16'h9000);
        send(16'h0000);
        check(rx, 16'h9042);
        $display("readback done");
        send(16'hb001);
        wp_n = 1'b0;
        repeat (4) @(posedge clk);
        send(16'hb0ff);
        send(16'hf000);
        send(16'h3099);
        check(wiper_pos, 16'hc301);
        send(16'h1000);
        check(wiper_pos, 16'hc342);
        send(16'h9000);
        send(16'h0000);
        check(rx, 16'h9042);
        wp_n = 1'b1;
        $display("protect done");
        host.xfer(16'hb077, 15, rx);
        repeat (4) @(posedge clk);
        check(wiper_pos, 16'hc342);
        $display("short word done");
        @(posedge clk);
        #1;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(wiper_pos, 16'h0000);
        sys_rst = 1'b0;
        wait_ready();
        check(wiper_pos, 16'h8080);
        $display("reset done");
        results();
    end
endmodule : tb_top
